// >>> inc/sa_capcmp_pkg.sv
// constants, field layout and types of the two-channel capture/compare block
package sa_capcmp_pkg;

    // register indices; the byte address is four times the index
    localparam logic [3:0] IDX_CHAN_A_CTRL = 4'h0;
    localparam logic [3:0] IDX_CHAN_A_VAL = 4'h2;
    localparam logic [3:0] IDX_CHAN_B_CTRL = 4'h4;
    localparam logic [3:0] IDX_CHAN_B_VAL = 4'h6;
    localparam int ADR_W = 6;
    localparam int IDX_LSB = 2;

    // control/status word field positions
    localparam int FLAG_BIT = 15;
    localparam int LEVEL_HI = 14;
    localparam int LEVEL_LO = 12;
    localparam int ARB_TOP_BIT = 11;
    localparam int IRQ_EN_BIT = 10;
    localparam int TB_SEL_BIT = 8;
    localparam int PIN_STATUS_BIT = 7;
    localparam int FORCE_BIT = 5;
    localparam int EDOUT_BIT = 4;
    localparam int OP_HI = 1;
    localparam int OP_LO = 0;

    // reset values
    localparam logic [2:0] LEVEL_RST = 3'h0;
    localparam logic ARB_TOP_RST = 1'b0;
    localparam logic IRQ_EN_RST = 1'b0;

    typedef enum logic [1:0] {
        CAPTURE_OP = 2'h0,
        PORT_OP = 2'h1,
        COMPARE_OP = 2'h2,
        COMPARE_TOGGLE_OP = 2'h3
    } op_select_t;

    typedef struct packed {
        logic timebase_select;
        logic edout;
        op_select_t op_select;
    } chan_ctrl_t;

    localparam chan_ctrl_t CHAN_CTRL_RST = '{1'b0, 1'b0, CAPTURE_OP};

    // interrupt request towards the module bus arbiter
    typedef struct packed {
        logic req;
        logic [2:0] level;
        logic [3:0] arbitration_number;
        logic chan_b;
    } irq_out_t;

endpackage

// >>> sim/sa_capcmp_far.sv
// far side model: one time base counter feeding both buses, and channel pin drivers
`timescale 1ns/1ns
module sa_capcmp_far (
    // clock and control from the bench
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [1:0] i_drv,
    // pin outputs of the block
    input wire logic [1:0] i_pin,
    input wire logic [1:0] i_pin_oe,
    // towards the block
    output logic [15:0] o_tb_a,
    output logic [15:0] o_tb_b,
    output logic [1:0] o_pin_lvl
);
    logic [15:0] cnt = 16'h1234;
    // counter only moves when asked, so a capture sees a known count
    always @(posedge i_clk) begin
        if (i_run) begin
            cnt <= cnt + 16'h0001;
        end
    end
    assign o_tb_a = cnt;
    // bus b counts the other way so a wrong bus select shows
    assign o_tb_b = ~cnt;
    // wire level from both parties
    assign o_pin_lvl = (i_pin_oe & i_pin) | (~i_pin_oe & i_drv);
endmodule

// >>> sim/single_action_capture_compare_tb_top.sv
// self-checking bench for the two-channel capture/compare block
`timescale 1ns/1ns
module single_action_capture_compare_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    logic frz = 1'b0;
    logic run = 1'b0;
    logic [1:0] drv = 2'h2;
    logic [2:0] arb_low = 3'h0;
    logic [15:0] tb_a;
    logic [15:0] tb_b;
    logic [1:0] pin_lvl;
    logic [1:0] pin;
    logic [1:0] pin_oe;
    sa_capcmp_pkg::irq_out_t irq;
    int n_fail = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h0001668A;
    // behavioural model state
    logic [2:0] lvl;
    logic arb;
    logic en;
    logic [1:0] flg;
    logic [1:0] arm;
    logic [1:0] tbs;
    logic [1:0] edo;
    logic [1:0] pout;
    sa_capcmp_pkg::op_select_t md [2];
    logic [15:0] dv [2];
    sa_capcmp_pkg::op_select_t ops [3];
    logic [15:0] q;

    always #5 clk = ~clk;

    sa_capcmp dut_u (.i_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'h3), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_tb_a(tb_a), .i_tb_b(tb_b), .i_freeze(frz), .i_pin(pin_lvl),
        .o_pin(pin), .o_pin_oe(pin_oe), .i_arb_low(arb_low), .o_irq(irq));
    sa_capcmp_far far_u (.i_clk(clk), .i_run(run), .i_drv(drv), .i_pin(pin),
        .i_pin_oe(pin_oe), .o_tb_a(tb_a), .o_tb_b(tb_b), .o_pin_lvl(pin_lvl));

    ////////////////////////////////////////
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction

    task automatic final_report();
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // classic cycle; master never assumes the answer delay
    task automatic wb(input logic w, input logic [3:0] ix, input logic [15:0] d,
            output logic [15:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {ix, 2'h0};
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    function automatic logic [15:0] ec(input int c);
        logic ps;
        ps = (md[c] == sa_capcmp_pkg::CAPTURE_OP) ? drv[c] : pout[c];
        return {flg[c], c ? 5'h00 : {lvl, arb, en}, 1'b0, tbs[c], ps, 2'h0, edo[c], 2'h0, md[c]};
    endfunction

    task automatic rd_ctrl(input int c);
        wb(1'b0, c ? sa_capcmp_pkg::IDX_CHAN_B_CTRL : sa_capcmp_pkg::IDX_CHAN_A_CTRL, 16'h0000, q);
        chk("ctrl", ec(c), q);
        if (flg[c]) arm[c] = 1'b1;
    endtask

    task automatic rd_dat(input int c);
        wb(1'b0, c ? sa_capcmp_pkg::IDX_CHAN_B_VAL : sa_capcmp_pkg::IDX_CHAN_A_VAL, 16'h0000, q);
        chk("data", dv[c], q);
    endtask

    // unused and pin status bits are written as ones on purpose; channel b also gets the model's level, arb and enable bits
    task automatic wr_ctrl(input int c, input logic f, input logic frc);
        if (arm[c] && !f) flg[c] = 1'b0;
        arm[c] = 1'b0;
        wb(1'b1, c ? sa_capcmp_pkg::IDX_CHAN_B_CTRL : sa_capcmp_pkg::IDX_CHAN_A_CTRL,
            {f, lvl, arb, en, 1'b1, tbs[c], 2'h3, frc, edo[c], 2'h3, md[c]}, q);
        case (md[c])
            sa_capcmp_pkg::COMPARE_OP: if (frc) pout[c] = edo[c];
            sa_capcmp_pkg::COMPARE_TOGGLE_OP: if (frc) pout[c] = ~pout[c];
            default: pout[c] = edo[c];
        endcase
    endtask

    task automatic cap(input int c);
        dv[c] = tbs[c] ? tb_b : tb_a;
        flg[c] = 1'b1;
        arm[c] = 1'b0;
    endtask

    task automatic match(input int c);
        flg[c] = 1'b1;
        arm[c] = 1'b0;
        if (md[c] == sa_capcmp_pkg::COMPARE_OP) pout[c] = edo[c];
        if (md[c] == sa_capcmp_pkg::COMPARE_TOGGLE_OP) pout[c] = ~pout[c];
    endtask

    task automatic chk_pins();
        repeat (2) @(posedge clk);
        chk("pin", {14'h0000, pout}, {14'h0000, pin});
        chk("pin_oe", {14'h0000, md[1] != sa_capcmp_pkg::CAPTURE_OP,
            md[0] != sa_capcmp_pkg::CAPTURE_OP}, {14'h0000, pin_oe});
        chk("irq", {7'h00, (|flg) & en & (lvl != 3'h0), lvl, arb, arb_low, flg[1] & ~flg[0]},
            {7'h00, irq});
    endtask

    ////////////////////////////////////////
    initial begin
        #200000;
        n_fail++;
        final_report();
    end

    initial begin
        {lvl, arb, en, flg, arm, tbs, edo, pout} = 15'h0000;
        md[0] = sa_capcmp_pkg::CAPTURE_OP;
        md[1] = sa_capcmp_pkg::CAPTURE_OP;
        ops = '{sa_capcmp_pkg::COMPARE_OP, sa_capcmp_pkg::COMPARE_TOGGLE_OP,
            sa_capcmp_pkg::PORT_OP};
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        chk_pins();
        rd_ctrl(0);
        rd_ctrl(1);
        wb(1'b1, 4'h1, rnd(), q);
        wb(1'b0, 4'h1, 16'h0000, q);
        chk("unmapped", 16'h0000, q);
        q = rnd();
        lvl = q[2:0] | 3'h1;
        arb = q[3];
        arb_low <= q[6:4];
        en = 1'b1;
        tbs = 2'h1;
        edo = 2'h1;
        wr_ctrl(0, 1'b1, 1'b1);
        wr_ctrl(1, 1'b1, 1'b1);
        rd_ctrl(0);
        rd_ctrl(1);
        // a rises, b falls: both capture on their chosen edge
        drv <= 2'h1;
        repeat (6) @(posedge clk);
        cap(0);
        cap(1);
        rd_dat(0);
        rd_dat(1);
        rd_ctrl(0);
        rd_ctrl(1);
        chk_pins();
        run <= 1'b1;
        repeat (5) @(posedge clk);
        run <= 1'b0;
        drv <= 2'h2;
        repeat (6) @(posedge clk);
        drv <= 2'h1;
        repeat (6) @(posedge clk);
        cap(0);
        cap(1);
        wr_ctrl(0, 1'b0, 1'b0);
        rd_dat(0);
        rd_dat(1);
        rd_ctrl(0);
        wr_ctrl(0, 1'b0, 1'b0);
        rd_ctrl(0);
        chk_pins();
        rd_ctrl(1);
        wr_ctrl(1, 1'b0, 1'b0);
        rd_ctrl(1);
        frz <= 1'b1;
        drv <= 2'h2;
        repeat (6) @(posedge clk);
        drv <= 2'h1;
        repeat (6) @(posedge clk);
        frz <= 1'b0;
        rd_ctrl(0);
        rd_dat(0);
        for (int i = 0; i < 3; i++) begin
            for (int c = 0; c < 2; c++) begin
                md[c] = ops[i];
                wr_ctrl(c, 1'b1, 1'b0);
                edo[c] = ~edo[c];
                wr_ctrl(c, 1'b1, 1'b0);
                q = tbs[c] ? tb_b : tb_a;
                dv[c] = tbs[c] ? q - 16'h0008 : q + 16'h0008;
                wb(1'b1, c ? sa_capcmp_pkg::IDX_CHAN_B_VAL : sa_capcmp_pkg::IDX_CHAN_A_VAL,
                    dv[c], q);
            end
            run <= 1'b1;
            repeat (20) @(posedge clk);
            run <= 1'b0;
            match(0);
            match(1);
            chk_pins();
            rd_ctrl(0);
            rd_ctrl(1);
        end
        // force from port into compare, then toggle
        md[0] = sa_capcmp_pkg::COMPARE_OP;
        wr_ctrl(0, 1'b1, 1'b0);
        edo[0] = 1'b1;
        wr_ctrl(0, 1'b1, 1'b1);
        chk_pins();
        md[0] = sa_capcmp_pkg::COMPARE_TOGGLE_OP;
        wr_ctrl(0, 1'b1, 1'b1);
        chk_pins();
        rd_ctrl(0);
        wr_ctrl(1, 1'b1, 1'b1);
        chk_pins();
        // mid-run reset: control clears, data words keep their value
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        {lvl, arb, en, flg, arm, tbs, edo, pout} = 15'h0000;
        md[0] = sa_capcmp_pkg::CAPTURE_OP;
        md[1] = sa_capcmp_pkg::CAPTURE_OP;
        chk_pins();
        rd_dat(0);
        rd_dat(1);
        rd_ctrl(0);
        final_report();
    end
endmodule

// >>> verilog/sa_capcmp.sv
// two-channel single-action capture/compare timer with wishbone register slave
//
// Summary of operation
// - capture or compare completion sets that channel's event flag
// - flag set only by hardware; cleared by read-then-zero-write or reset only
// - request raised when flag, enable set and level non-zero
// - capture with flag already set still latches count; flag stays set
// - compare with flag set still acts on pin or internally; flag stays
// - flag clears only after reading it as one then writing zero
// - event between that read and the zero write keeps the flag set
// - level field bits 14..12: zero disables, 1..7 select priority, reset zero
// - level, arbitration bit and enable live in channel A, govern both
// - bit 11 is top bit of arbitration number with three external low bits
// - bit 8 selects time base B when set, A when clear; reset clear
// - bit 7 shows synced pin in capture, output flip-flop in output modes
// - pin status bit read-only, unaffected by writes and reset; here reset clears the synchronizers and output flip-flop it reads
// - force bit does nothing in capture and port modes
// - force bit 5 acts as compare match on output, no flag, reads zero
// - edout written together with force drives the new level
// - capture edge by bit 4: one rising, zero falling; reset clear
// - compare mode: bit 4 is level driven at next match or force
// - port mode drives bit 4 straight onto the pin
// - mode bits 1..0: 00 capture, 01 port, 10 compare, 11 toggle
// - 16-bit data register holds capture or compare value; reset leaves it
// - channel B control word has the same per-channel bits for channel B
// - capture latches the selected time base count into the data register
// - compare match when data register equals selected time base value
// - freeze halts capture and compare; registers and force stay usable
// - simultaneous requests: channel A has priority over channel B
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns

module sa_capcmp #(
    parameter int TB_W = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [sa_capcmp_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // time base buses and freeze
    input wire logic [TB_W-1:0] i_tb_a,
    input wire logic [TB_W-1:0] i_tb_b,
    input wire logic i_freeze,
    // channel pins, index 0 is channel A
    input wire logic [1:0] i_pin,
    output logic [1:0] o_pin,
    output logic [1:0] o_pin_oe,
    // interrupt arbitration
    input wire logic [2:0] i_arb_low,
    output sa_capcmp_pkg::irq_out_t o_irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [TB_W-1:0] pick_tb(input logic sel, input logic [TB_W-1:0] a,
                                                input logic [TB_W-1:0] b);
        pick_tb = sel ? b : a;
    endfunction

    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        lane_merge = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    sa_capcmp_pkg::chan_ctrl_t ctrl_r [2];
    sa_capcmp_pkg::chan_ctrl_t ctrl_nxt [2];
    logic [15:0] data_r [2];
    logic [1:0] flag_r;
    logic [1:0] arm_r;
    logic [1:0] out_r;
    logic [1:0] match_prev_r;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] sync3_r;
    logic [TB_W-1:0] tb_a_r;
    logic [TB_W-1:0] tb_b_r;
    logic [2:0] level_r;
    logic arb_top_r;
    logic irq_en_r;

    logic [TB_W-1:0] tb_sel [2];
    logic [1:0] cap_ev;
    logic [1:0] cmp_ev;
    logic [1:0] wr_ctrl;
    logic [1:0] wr_val;
    logic [1:0] rd_ctrl;
    logic [1:0] force_go;
    logic [1:0] pin_status;
    logic [15:0] ctrl_word [2];
    logic [15:0] wr_word [2];
    logic [15:0] rd_word;
    logic [3:0] idx;
    logic bus_req;
    logic bus_wr;

    ////////////////////////////////////////////////////////////////////////////////
    // input registering

    // sync1 is read by sync2 only; edges are taken from sync2/sync3
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
            sync3_r <= 2'h0;
        end else begin
            sync1_r <= i_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tb_a_r <= '0;
            tb_b_r <= '0;
        end else begin
            tb_a_r <= i_tb_a;
            tb_b_r <= i_tb_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    assign idx = i_wb_adr[sa_capcmp_pkg::ADR_W-1:sa_capcmp_pkg::IDX_LSB];
    assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    // writes land on the edge where the master sees ack
    assign bus_wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            tb_sel[c] = pick_tb(ctrl_r[c].timebase_select, tb_a_r, tb_b_r);
            pin_status[c] = (ctrl_r[c].op_select == sa_capcmp_pkg::CAPTURE_OP)
                            ? sync2_r[c] : out_r[c];
            ctrl_word[c] = 16'h0000;
            ctrl_word[c][sa_capcmp_pkg::FLAG_BIT] = flag_r[c];
            ctrl_word[c][sa_capcmp_pkg::TB_SEL_BIT] = ctrl_r[c].timebase_select;
            ctrl_word[c][sa_capcmp_pkg::PIN_STATUS_BIT] = pin_status[c];
            ctrl_word[c][sa_capcmp_pkg::EDOUT_BIT] = ctrl_r[c].edout;
            ctrl_word[c][sa_capcmp_pkg::OP_HI:sa_capcmp_pkg::OP_LO] = ctrl_r[c].op_select;
            wr_word[c] = 16'h0000;
        end
        // shared fields appear in channel A's word only
        ctrl_word[0][sa_capcmp_pkg::LEVEL_HI:sa_capcmp_pkg::LEVEL_LO] = level_r;
        ctrl_word[0][sa_capcmp_pkg::ARB_TOP_BIT] = arb_top_r;
        ctrl_word[0][sa_capcmp_pkg::IRQ_EN_BIT] = irq_en_r;
        for (int c = 0; c < 2; c++) begin
            wr_word[c] = lane_merge(ctrl_word[c], i_wb_dat, i_wb_sel);
        end
        wr_ctrl[0] = bus_wr && (idx == sa_capcmp_pkg::IDX_CHAN_A_CTRL);
        wr_ctrl[1] = bus_wr && (idx == sa_capcmp_pkg::IDX_CHAN_B_CTRL);
        wr_val[0] = bus_wr && (idx == sa_capcmp_pkg::IDX_CHAN_A_VAL);
        wr_val[1] = bus_wr && (idx == sa_capcmp_pkg::IDX_CHAN_B_VAL);
        rd_ctrl[0] = (idx == sa_capcmp_pkg::IDX_CHAN_A_CTRL);
        rd_ctrl[1] = (idx == sa_capcmp_pkg::IDX_CHAN_B_CTRL);
        // reserved and unmapped words read zero; force always reads zero
        unique case (idx)
            sa_capcmp_pkg::IDX_CHAN_A_CTRL: rd_word = ctrl_word[0];
            sa_capcmp_pkg::IDX_CHAN_A_VAL: rd_word = data_r[0];
            sa_capcmp_pkg::IDX_CHAN_B_CTRL: rd_word = ctrl_word[1];
            sa_capcmp_pkg::IDX_CHAN_B_VAL: rd_word = data_r[1];
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= bus_req;
            if (bus_req) begin
                o_wb_dat <= {16'h0000, rd_word};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control fields

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            ctrl_nxt[c] = ctrl_r[c];
            force_go[c] = 1'b0;
            if (wr_ctrl[c]) begin
                ctrl_nxt[c].timebase_select = wr_word[c][sa_capcmp_pkg::TB_SEL_BIT];
                ctrl_nxt[c].edout = wr_word[c][sa_capcmp_pkg::EDOUT_BIT];
                ctrl_nxt[c].op_select = sa_capcmp_pkg::op_select_t'(
                    wr_word[c][sa_capcmp_pkg::OP_HI:sa_capcmp_pkg::OP_LO]);
                // force only matters in the two compare modes
                force_go[c] = wr_word[c][sa_capcmp_pkg::FORCE_BIT]
                              && ctrl_nxt[c].op_select[1];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_r[0] <= sa_capcmp_pkg::CHAN_CTRL_RST;
            ctrl_r[1] <= sa_capcmp_pkg::CHAN_CTRL_RST;
        end else begin
            ctrl_r[0] <= ctrl_nxt[0];
            ctrl_r[1] <= ctrl_nxt[1];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            level_r <= sa_capcmp_pkg::LEVEL_RST;
            arb_top_r <= sa_capcmp_pkg::ARB_TOP_RST;
            irq_en_r <= sa_capcmp_pkg::IRQ_EN_RST;
        end else if (wr_ctrl[0]) begin
            level_r <= wr_word[0][sa_capcmp_pkg::LEVEL_HI:sa_capcmp_pkg::LEVEL_LO];
            arb_top_r <= wr_word[0][sa_capcmp_pkg::ARB_TOP_BIT];
            irq_en_r <= wr_word[0][sa_capcmp_pkg::IRQ_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // capture and compare

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            // edge seen on synced pin, polarity from edout
            cap_ev[c] = !i_freeze && (ctrl_r[c].op_select == sa_capcmp_pkg::CAPTURE_OP)
                        && (ctrl_r[c].edout ? (sync2_r[c] && !sync3_r[c])
                                            : (!sync2_r[c] && sync3_r[c]));
            // first cycle of equality only, so a slow time base toggles once
            cmp_ev[c] = !i_freeze && (ctrl_r[c].op_select != sa_capcmp_pkg::CAPTURE_OP)
                        && (data_r[c] == tb_sel[c]) && !match_prev_r[c];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            match_prev_r <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                match_prev_r[c] <= (data_r[c] == tb_sel[c]);
            end
        end
    end

    // data is deliberately left out of reset; a capture beats a bus write
    always_ff @(posedge i_clk) begin
        for (int c = 0; c < 2; c++) begin
            if (cap_ev[c]) begin
                data_r[c] <= tb_sel[c];
            end else if (wr_val[c]) begin
                data_r[c] <= lane_merge(data_r[c], i_wb_dat, i_wb_sel);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event flags

    // a read returning flag=1 arms the clear; any event disarms it
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flag_r <= 2'h0;
            arm_r <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (cap_ev[c] || cmp_ev[c]) begin
                    flag_r[c] <= 1'b1;
                    arm_r[c] <= 1'b0;
                end else if (wr_ctrl[c]) begin
                    if (arm_r[c] && !wr_word[c][sa_capcmp_pkg::FLAG_BIT]) begin
                        flag_r[c] <= 1'b0;
                    end
                    arm_r[c] <= 1'b0;
                end else if (o_wb_ack && !i_wb_we && rd_ctrl[c]
                             && o_wb_dat[sa_capcmp_pkg::FLAG_BIT]) begin
                    arm_r[c] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output flip-flops and pins

    // uses the value being written, so edout and force in one write line up
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_r <= 2'h0;
            o_pin_oe <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                o_pin_oe[c] <= (ctrl_nxt[c].op_select != sa_capcmp_pkg::CAPTURE_OP);
                unique case (ctrl_nxt[c].op_select)
                    sa_capcmp_pkg::CAPTURE_OP,
                    sa_capcmp_pkg::PORT_OP: out_r[c] <= ctrl_nxt[c].edout;
                    sa_capcmp_pkg::COMPARE_OP: begin
                        if (cmp_ev[c] || force_go[c]) begin
                            out_r[c] <= ctrl_nxt[c].edout;
                        end
                    end
                    sa_capcmp_pkg::COMPARE_TOGGLE_OP: begin
                        if (cmp_ev[c] || force_go[c]) begin
                            out_r[c] <= !out_r[c];
                        end
                    end
                endcase
            end
        end
    end

    assign o_pin = out_r;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt request

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= '0;
        end else begin
            o_irq.req <= irq_en_r && (level_r != 3'h0) && (|flag_r);
            o_irq.level <= level_r;
            o_irq.arbitration_number <= {arb_top_r, i_arb_low};
            o_irq.chan_b <= !flag_r[0] && flag_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    flag_set_a: assert property ((cap_ev[0] || cmp_ev[0]) |=> flag_r[0])
        else $error("channel A event did not set flag");
    flag_hold_a: assert property (!flag_r[1] && !cap_ev[1] && !cmp_ev[1]
        |=> !flag_r[1])
        else $error("channel B flag set without event");
    clear_armed_a: assert property ($fell(flag_r[0])
        |-> $past(arm_r[0]) && $past(wr_ctrl[0]))
        else $error("flag cleared without read then zero write");
    irq_req_a: assert property (flag_r[1] && irq_en_r && level_r != 3'h0
        |=> o_irq.req)
        else $error("interrupt request missing");
    capture_value_a: assert property (cap_ev[0] |=> data_r[0] == $past(tb_sel[0]))
        else $error("capture did not latch time base");
    force_zero_a: assert property (o_wb_ack && rd_ctrl[0]
        |-> !o_wb_dat[sa_capcmp_pkg::FORCE_BIT])
        else $error("force bit read as one");
    port_pin_a: assert property (ctrl_r[1].op_select == sa_capcmp_pkg::PORT_OP
        |-> o_pin[1] == ctrl_r[1].edout && o_pin_oe[1])
        else $error("port mode pin differs from edout");
    freeze_halt_a: assert property (i_freeze
        |=> !$rose(flag_r[0]) && !$rose(flag_r[1]))
        else $error("flag rose during freeze");
    prio_a_a: assert property (o_irq.chan_b |-> !$past(flag_r[0]))
        else $error("channel B chosen over pending A");
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held two cycles");

    capture_c: cover property (cap_ev[0] ##1 flag_r[0]);
    toggle_c: cover property (cmp_ev[1]
        && ctrl_r[1].op_select == sa_capcmp_pkg::COMPARE_TOGGLE_OP);
    clear_c: cover property (flag_r[0] ##1 !flag_r[0]);
    force_c: cover property (force_go[0] ##1 o_pin[0] == ctrl_r[0].edout);

endmodule
